// ### endian_byte_lane_steering.v
// Byte-lane steering between internal bus, disk data bus and host CPU bus
`timescale 1ns/1ns
`include "lane_steer_map.vh"

// Function
// - Internal bus first byte sits on 15:8
// - Disk bus first byte sits on 7:0
// - Swap 0: DMA words pass straight through
// - Swap 1: DMA exchanges upper and lower bytes
// - Data register read lanes follow swap setting
// - Data register write lanes follow swap setting
// - Burst data write: first byte low unless swapped
// - Auto status: none for data, task-file read
// - Task-file read copies low byte twice
// - Task-file writes drive data on the low byte and zero on the upper byte
// - Host bus starts big-endian, even on upper
// - Read of switch address sets host lanes from endian bit
// - Earlier FIFO byte on lane per endianness
// - Little-endian swaps halves of register pairs
module endian_byte_lane_steering (
  input wire clk,
  input wire rst,
  input wire ce,
  // Host CPU bus
  input wire [7:0] host_addr,
  input wire [1:0] host_be,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_data_bus_in,
  output wire [15:0] host_data_bus_out,
  // Received byte pairs, first byte on 15:8
  input wire [15:0] rx_word,
  input wire rx_valid,
  output wire rx_ready,
  // Internal bus, DMA towards the disk
  input wire [15:0] int_wr_data,
  input wire int_wr_valid,
  output wire int_wr_ready,
  // Internal bus, DMA from the disk
  output wire [15:0] int_rd_data,
  output wire int_rd_valid,
  // Disk port control
  input wire disk_swap,
  input wire disk_task_file,
  input wire disk_dma_launch,
  input wire disk_dma_to_disk,
  input wire disk_dma_take,
  input wire disk_dma_read_strobe,
  input wire disk_single_read_cmd,
  input wire disk_single_write_cmd,
  input wire auto_status_fetch_enable,
  input wire auto_status_fetch,
  input wire disk_burst_write_cmd,
  input wire [7:0] disk_burst_write_value,
  input wire [7:0] disk_write_value_byte0,
  input wire [7:0] disk_write_value_byte1,
  output wire [7:0] disk_read_value_byte0,
  output wire [7:0] disk_read_value_byte1,
  // Disk data bus, two-way
  input wire [15:0] disk_data_bus_in,
  output wire [15:0] disk_data_bus_out,
  output wire disk_data_bus_oe_n,
  output wire disk_wr_strobe,
  output wire disk_rd_strobe
);

  // Host side state
  reg cpu_endian_r; // Endian request bit written by software
  reg lanes_le_r; // Lanes reversed, little-endian in force
  reg [15:0] wake_r; // Wakeup timer pair, high byte at 15:8
  reg [15:0] host_out_r; // Host read data
  // Disk side state
  reg [7:0] rd_val0_r;
  reg [7:0] rd_val1_r;
  reg [15:0] disk_out_r;
  reg disk_oe_n_r;
  reg disk_wr_r;
  reg disk_rd_r;
  reg [7:0] burst_first_r; // First byte of a burst word
  reg burst_half_r; // First byte held, waiting for second
  reg [15:0] int_rd_r;
  reg int_rd_valid_r;

  // FIFO wires
  wire [15:0] dma_word;
  wire dma_valid;
  wire dma_pop;
  wire [15:0] rx_head;
  wire rx_head_valid;
  wire rx_pop;

  // Lane byte addresses for the current access
  wire [6:0] word_addr = host_addr[7:1];
  wire [7:0] up_addr = {word_addr, lanes_le_r};
  wire [7:0] lo_addr = {word_addr, ~lanes_le_r};
  wire up_hit = host_be[1];
  wire lo_hit = host_be[0];
  wire rx_word_hit = (word_addr == `RX_FIFO_WORD);

  assign host_data_bus_out = host_out_r;
  assign int_rd_data = int_rd_r;
  assign int_rd_valid = int_rd_valid_r;
  assign disk_read_value_byte0 = rd_val0_r;
  assign disk_read_value_byte1 = rd_val1_r;
  assign disk_data_bus_out = disk_out_r;
  assign disk_data_bus_oe_n = disk_oe_n_r;
  assign disk_wr_strobe = disk_wr_r;
  assign disk_rd_strobe = disk_rd_r;

  // Exchange the two bytes of a word
  function [15:0] byte_exchange;
    input [15:0] w;
    begin
      byte_exchange = {w[7:0], w[15:8]};
    end
  endfunction

  // Register pairs trade addresses of their halves when little-endian
  function [7:0] pair_map;
    input [7:0] a;
    input le;
    begin
      if (le && (a[7:1] == `WAKE_PAIR_WORD))
        pair_map = {a[7:1], ~a[0]};
      else
        pair_map = a;
    end
  endfunction

  // Byte readable at a given byte address
  function [7:0] reg_byte;
    input [7:0] a;
    input endian_bit;
    input le;
    input [15:0] wake;
    reg [7:0] cfg;
    begin
      cfg = `BYTE_ZERO;
      cfg[`CFG_ENDIAN_BIT] = endian_bit;
      cfg[`CFG_STATE_BIT] = le;
      case (a)
        `CFG_ADDR: reg_byte = cfg;
        `WAKE_HI_ADDR: reg_byte = wake[15:8];
        `WAKE_LO_ADDR: reg_byte = wake[7:0];
        default: reg_byte = `BYTE_ZERO;
      endcase
    end
  endfunction

  wire [7:0] up_phys = pair_map(up_addr, lanes_le_r);
  wire [7:0] lo_phys = pair_map(lo_addr, lanes_le_r);
  // The switch fires on a read touching the switch byte on either lane
  wire switch_rd = host_rd & ((up_hit & (up_addr == `LANE_SWITCH_ADDR)) |
                              (lo_hit & (lo_addr == `LANE_SWITCH_ADDR)));

  // Received pairs pop on a host read of the FIFO word
  assign rx_pop = host_rd & rx_word_hit & rx_head_valid;

  // Buffer of received byte pairs for the host
  lane_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW),
    .CW(`FIFO_CW)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_data(rx_word),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(rx_head),
    .out_valid(rx_head_valid),
    .out_ready(rx_pop)
  );

  // Host register writes, lane switch and read data
  always @(posedge clk)
  begin
    if (rst)
    begin
      cpu_endian_r <= 1'b0;
      lanes_le_r <= 1'b0;
      wake_r <= `WAKE_RESET;
      host_out_r <= `WORD_ZERO;
    end
    else if (ce)
    begin
      if (host_wr)
      begin
        // Before the switch a little-endian CPU lands here via the other lane
        if (up_hit && (up_phys == `CFG_ADDR))
          cpu_endian_r <= host_data_bus_in[`UPPER_LANE_LSB + `CFG_ENDIAN_BIT];
        if (lo_hit && (lo_phys == `CFG_ADDR))
          cpu_endian_r <= host_data_bus_in[`CFG_ENDIAN_BIT];
        if (up_hit && (up_phys == `WAKE_HI_ADDR))
          wake_r[15:8] <= host_data_bus_in[15:8];
        if (up_hit && (up_phys == `WAKE_LO_ADDR))
          wake_r[7:0] <= host_data_bus_in[15:8];
        if (lo_hit && (lo_phys == `WAKE_HI_ADDR))
          wake_r[15:8] <= host_data_bus_in[7:0];
        if (lo_hit && (lo_phys == `WAKE_LO_ADDR))
          wake_r[7:0] <= host_data_bus_in[7:0];
      end
      // Lanes follow the endian bit only at the switch read
      if (switch_rd)
        lanes_le_r <= cpu_endian_r;
      if (host_rd)
      begin
        if (rx_word_hit)
        begin
          // Earlier byte goes to the lane holding the even address
          if (!rx_head_valid)
            host_out_r <= `WORD_ZERO;
          else if (lanes_le_r)
            host_out_r <= byte_exchange(rx_head);
          else
            host_out_r <= rx_head;
        end
        else
        begin
          host_out_r[15:8] <= up_hit ? reg_byte(up_phys, cpu_endian_r, lanes_le_r, wake_r)
                                     : `BYTE_ZERO;
          host_out_r[7:0] <= lo_hit ? reg_byte(lo_phys, cpu_endian_r, lanes_le_r, wake_r)
                                    : `BYTE_ZERO;
        end
      end
    end
  end

  // Words from the internal bus wait here for the disk to take them
  assign dma_pop = disk_dma_launch & disk_dma_to_disk & disk_dma_take & dma_valid;

  lane_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW),
    .CW(`FIFO_CW)
  ) u_dma_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_data(int_wr_data),
    .in_valid(int_wr_valid),
    .in_ready(int_wr_ready),
    .out_data(dma_word),
    .out_valid(dma_valid),
    .out_ready(dma_pop)
  );

  // Disk side: DMA steering and register access steering
  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_val0_r <= `BYTE_ZERO;
      rd_val1_r <= `BYTE_ZERO;
      disk_out_r <= `WORD_ZERO;
      disk_oe_n_r <= 1'b1;
      disk_wr_r <= 1'b0;
      disk_rd_r <= 1'b0;
      burst_first_r <= `BYTE_ZERO;
      burst_half_r <= 1'b0;
      int_rd_r <= `WORD_ZERO;
      int_rd_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      // Drive and strobes last one cycle unless renewed
      disk_oe_n_r <= 1'b1;
      disk_wr_r <= 1'b0;
      disk_rd_r <= 1'b0;
      int_rd_valid_r <= 1'b0;
      if (disk_dma_launch)
      begin
        // DMA owns the port; register commands are ignored
        if (dma_pop)
        begin
          disk_out_r <= disk_swap ? byte_exchange(dma_word) : dma_word;
          disk_oe_n_r <= 1'b0;
          disk_wr_r <= 1'b1;
        end
        if (!disk_dma_to_disk && disk_dma_read_strobe)
        begin
          // Disk low byte is first, internal high byte is first
          int_rd_r <= disk_swap ? byte_exchange(disk_data_bus_in)
                                : disk_data_bus_in;
          int_rd_valid_r <= 1'b1;
        end
      end
      else if (disk_single_read_cmd ||
               (auto_status_fetch_enable && auto_status_fetch && disk_task_file))
      begin
        // Auto status on the data register does nothing
        disk_rd_r <= 1'b1;
        if (disk_task_file)
        begin
          rd_val0_r <= disk_data_bus_in[7:0];
          rd_val1_r <= disk_data_bus_in[7:0];
        end
        else if (disk_swap)
        begin
          rd_val1_r <= disk_data_bus_in[15:8];
          rd_val0_r <= disk_data_bus_in[7:0];
        end
        else
        begin
          rd_val0_r <= disk_data_bus_in[15:8];
          rd_val1_r <= disk_data_bus_in[7:0];
        end
      end
      else if (disk_single_write_cmd)
      begin
        disk_oe_n_r <= 1'b0;
        disk_wr_r <= 1'b1;
        if (disk_task_file)
          disk_out_r <= {`BYTE_ZERO, disk_swap ? disk_write_value_byte0
                                               : disk_write_value_byte1};
        else if (disk_swap)
          disk_out_r <= {disk_write_value_byte1, disk_write_value_byte0};
        else
          disk_out_r <= {disk_write_value_byte0, disk_write_value_byte1};
      end
      else if (disk_burst_write_cmd)
      begin
        if (disk_task_file)
        begin
          // Task file takes every burst byte on the low lane
          disk_out_r <= {`BYTE_ZERO, disk_burst_write_value};
          disk_oe_n_r <= 1'b0;
          disk_wr_r <= 1'b1;
        end
        else if (!burst_half_r)
        begin
          // Hold the first byte until its partner arrives
          burst_first_r <= disk_burst_write_value;
          burst_half_r <= 1'b1;
        end
        else
        begin
          if (disk_swap)
            disk_out_r <= {burst_first_r, disk_burst_write_value};
          else
            disk_out_r <= {disk_burst_write_value, burst_first_r};
          burst_half_r <= 1'b0;
          disk_oe_n_r <= 1'b0;
          disk_wr_r <= 1'b1;
        end
      end
    end
  end

endmodule

// ### lane_steer_map.vh
// Address map, field positions, reset values and sizes for the byte-lane steering block
`ifndef LANE_STEER_MAP_VH
`define LANE_STEER_MAP_VH

// Host bus byte addresses and word addresses
`define CFG_ADDR 8'hB7
`define LANE_SWITCH_ADDR 8'hB9
`define WAKE_HI_ADDR 8'h24
`define WAKE_LO_ADDR 8'h25
`define WAKE_PAIR_WORD 7'h12
`define RX_FIFO_WORD 7'h18

// Fields of the CPU bus configuration register, upper lane offset and reset values
`define CFG_ENDIAN_BIT 0
`define CFG_STATE_BIT 7
`define CFG_RESET 8'h00
`define UPPER_LANE_LSB 8
`define WAKE_RESET 16'h0000

// Buffer shape
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define FIFO_CW 4

// Constant lane values
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000

`endif

// ### lane_fifo.v
// Small FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ns

module lane_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter CW = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  localparam [CW-1:0] DEPTH_C = DEPTH; // Entry count at full
  localparam [CW-1:0] ONE_C = 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
  reg [AW-1:0] wp_r; // Write pointer
  reg [AW-1:0] rp_r; // Read pointer
  reg [CW-1:0] cnt_r; // Words held in the array
  reg [CW-1:0] cnt_nxt;
  reg [WIDTH-1:0] out_data_r; // Head word, always from a register
  reg out_valid_r;
  reg in_ready_r; // Registered so the ready port comes from a flop

  wire push = in_valid & in_ready_r & ce;
  wire pop = out_valid_r & out_ready & ce;
  wire load = ~out_valid_r | pop;
  wire empty = (cnt_r == {CW{1'b0}});
  wire bypass = load & empty & push; // Straight to the head stage
  wire mem_wr = push & ~bypass;
  wire mem_rd = load & ~empty & ce;

  assign in_ready = in_ready_r;
  assign out_data = out_data_r;
  assign out_valid = out_valid_r;

  // Next fill level of the array
  always @*
  begin
    cnt_nxt = cnt_r;
    if (mem_wr & ~mem_rd)
      cnt_nxt = cnt_r + ONE_C;
    else if (mem_rd & ~mem_wr)
      cnt_nxt = cnt_r - ONE_C;
  end

  // Array writes carry no reset, only the data path
  always @(posedge clk)
  begin
    if (mem_wr)
      mem[wp_r] <= in_data;
  end

  // Pointers, level, head stage and ready flag
  always @(posedge clk)
  begin
    if (rst)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {CW{1'b0}};
      out_data_r <= {WIDTH{1'b0}};
      out_valid_r <= 1'b0;
      in_ready_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt < DEPTH_C);
      if (mem_wr)
        wp_r <= wp_r + 1'b1;
      if (mem_rd)
      begin
        // Refill head from the oldest stored word
        out_data_r <= mem[rp_r];
        rp_r <= rp_r + 1'b1;
        out_valid_r <= 1'b1;
      end
      else if (bypass)
      begin
        // Empty array: new word goes straight to the head
        out_data_r <= in_data;
        out_valid_r <= 1'b1;
      end
      else if (load)
        out_valid_r <= 1'b0;
    end
  end

endmodule

// ### disk_drive_model.sv
// Disk drive model on the two-way disk data bus
`timescale 1ns/1ns
module disk_drive_model (
  input wire clk,
  input wire oe_n,
  input wire [15:0] dev_out,
  input wire drive_en,
  input wire [15:0] drive_val,
  output wire [15:0] bus
);
  // Last level on the wire
  reg [15:0] last_r;
  // Track the wire so a released bus never repeats stale data
  always @(posedge clk)
    last_r <= bus;
  // Device wins while its enable is low; drive carries first byte on 7:0
  assign bus = !oe_n ? dev_out : (drive_en ? drive_val : ~last_r);
endmodule

// ### lane_steer_asserts.sv
// Port assertions for the byte-lane steering block
`timescale 1ns/1ns
module lane_steer_asserts (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire disk_swap,
  input wire disk_task_file,
  input wire disk_dma_launch,
  input wire disk_dma_to_disk,
  input wire disk_dma_read_strobe,
  input wire disk_single_read_cmd,
  input wire disk_single_write_cmd,
  input wire disk_burst_write_cmd,
  input wire auto_status_fetch_enable,
  input wire auto_status_fetch,
  input wire [7:0] disk_write_value_byte0,
  input wire [7:0] disk_write_value_byte1,
  input wire [7:0] disk_read_value_byte0,
  input wire [7:0] disk_read_value_byte1,
  input wire [15:0] disk_data_bus_in,
  input wire [15:0] disk_data_bus_out,
  input wire disk_data_bus_oe_n,
  input wire disk_rd_strobe,
  input wire [15:0] int_rd_data,
  input wire int_rd_valid
);
  // Register commands count only when enabled and no DMA runs
  wire idle = ce && !disk_dma_launch;
  wire auto = auto_status_fetch && auto_status_fetch_enable;
  wire rd_go = idle && disk_single_read_cmd;
  // Auto status claims the port only for task-file accesses
  wire auto_go = idle && !disk_single_read_cmd && auto && disk_task_file;
  // Data-register auto status with no other command that could drive
  wire auto_data = idle && auto && !disk_task_file && !disk_single_read_cmd &&
    !disk_single_write_cmd && !disk_burst_write_cmd;
  wire wr_go = idle && !disk_single_read_cmd && !auto_go && disk_single_write_cmd;
  wire dma_rd = ce && disk_dma_launch && !disk_dma_to_disk && disk_dma_read_strobe;
  wire [7:0] b0 = disk_write_value_byte0;
  wire [7:0] b1 = disk_write_value_byte1;
  wire [15:0] din = disk_data_bus_in;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_dma_straight:
    assert property (dma_rd && !disk_swap |=> int_rd_valid && int_rd_data == $past(din))
    else $error("dma word moved lanes with swap off");
  chk_dma_exchange:
    assert property (dma_rd && disk_swap |=> int_rd_data == {$past(din[7:0]), $past(din[15:8])})
    else $error("dma word not exchanged with swap on");
  chk_data_read:
    assert property (rd_go && !disk_task_file |=> disk_read_value_byte0 ==
      ($past(disk_swap) ? $past(din[7:0]) : $past(din[15:8])))
    else $error("data read byte0 on wrong lane");
  chk_task_read:
    assert property (rd_go && disk_task_file |=> disk_read_value_byte0 == $past(din[7:0])
      && disk_read_value_byte1 == $past(din[7:0]))
    else $error("task read not copied from low byte");
  chk_data_write:
    assert property (wr_go && !disk_task_file |=> !disk_data_bus_oe_n && disk_data_bus_out ==
      ($past(disk_swap) ? {$past(b1), $past(b0)} : {$past(b0), $past(b1)}))
    else $error("data write lanes wrong");
  chk_task_write:
    assert property (wr_go && disk_task_file |=> disk_data_bus_out[7:0] ==
      ($past(disk_swap) ? $past(b0) : $past(b1)))
    else $error("task write low byte wrong");
  chk_auto_none:
    assert property (auto_data |=> !disk_rd_strobe && disk_data_bus_oe_n)
    else $error("auto status on data register moved data");
  chk_auto_task:
    assert property (auto_go |=> disk_rd_strobe && disk_read_value_byte1 == $past(din[7:0]))
    else $error("auto status on task file did not read");
  chk_reset_idle:
    assert property ($fell(rst) |-> disk_data_bus_oe_n && !disk_rd_strobe && !int_rd_valid)
    else $error("outputs not idle after reset");
  // Main scenarios reached
  cover property (rd_go && disk_swap);
  cover property (wr_go && disk_task_file);
  cover property (dma_rd && disk_swap);
  cover property (auto_data);
endmodule
bind endian_byte_lane_steering lane_steer_asserts chk (.*);

// ### tb.sv
// Self-checking bench for the byte-lane steering block
`timescale 1ns/1ns
module tb;
  // Design inputs, named as its ports, and the drive model's drv_en and drv_val
  reg clk, rst, ce, host_wr, host_rd, rx_valid, int_wr_valid, disk_swap, disk_task_file;
  reg disk_dma_launch, disk_dma_to_disk, disk_dma_take, disk_dma_read_strobe;
  reg disk_single_read_cmd, disk_single_write_cmd, auto_status_fetch_enable;
  reg auto_status_fetch, disk_burst_write_cmd, drv_en;
  reg [7:0] host_addr, disk_burst_write_value, disk_write_value_byte0, disk_write_value_byte1;
  reg [1:0] host_be;
  reg [15:0] host_data_bus_in, rx_word, int_wr_data, drv_val;
  // Design outputs, the disk bus input and bench counters
  wire [15:0] host_data_bus_out, int_rd_data, disk_data_bus_in, disk_data_bus_out;
  wire [7:0] disk_read_value_byte0, disk_read_value_byte1;
  wire rx_ready, int_wr_ready, int_rd_valid, disk_data_bus_oe_n, disk_wr_strobe, disk_rd_strobe;
  integer mismatches, checks_done, cycles, s;
  endian_byte_lane_steering DUT (.clk, .rst, .ce, .host_addr, .host_be, .host_wr, .host_rd,
    .host_data_bus_in, .host_data_bus_out, .rx_word, .rx_valid, .rx_ready, .int_wr_data,
    .int_wr_valid, .int_wr_ready, .int_rd_data, .int_rd_valid, .disk_swap, .disk_task_file,
    .disk_dma_launch, .disk_dma_to_disk, .disk_dma_take, .disk_dma_read_strobe,
    .disk_single_read_cmd, .disk_single_write_cmd, .auto_status_fetch_enable,
    .auto_status_fetch, .disk_burst_write_cmd, .disk_burst_write_value,
    .disk_write_value_byte0, .disk_write_value_byte1, .disk_read_value_byte0,
    .disk_read_value_byte1, .disk_data_bus_in, .disk_data_bus_out, .disk_data_bus_oe_n,
    .disk_wr_strobe, .disk_rd_strobe);
  disk_drive_model drive (.clk(clk), .oe_n(disk_data_bus_oe_n), .dev_out(disk_data_bus_out),
    .drive_en(drv_en), .drive_val(drv_val), .bus(disk_data_bus_in));
  // 100 ns clock
  always #50 clk = ~clk;
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Word compare
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t word %h want %h", $time, got, exp);
      end
    end
  endtask
  // Flag compare
  task chk1(input got, input exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t flag %b want %b", $time, got, exp);
      end
    end
  endtask
  // One edge, then settle at the falling edge; pulses drop here
  task step;
    begin
      @(posedge clk);
      @(negedge clk);
      {host_wr, host_rd, rx_valid, int_wr_valid, disk_dma_take, disk_dma_read_strobe} = 0;
      {disk_single_read_cmd, disk_single_write_cmd, auto_status_fetch} = 0;
    end
  endtask
  // Host access; read data is settled after the step
  task hacc(input w, input [7:0] a, input [1:0] be, input [15:0] d);
    begin
      host_addr = a;
      host_be = be;
      host_data_bus_in = d;
      host_wr = w;
      host_rd = !w;
      step;
    end
  endtask
  // Push one received pair
  task rx_push(input [15:0] d);
    begin
      rx_word = d;
      rx_valid = 1;
      step;
    end
  endtask
  task t_host_be;
    begin
      hacc(0, 8'hB6, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'h0000);
      chk1(disk_data_bus_oe_n, 1'b1);
      chk1(rx_ready, 1'b1);
      chk1(int_wr_ready, 1'b1);
      hacc(1, 8'h24, 2'b11, 16'hA53C);
      hacc(1, 8'h25, 2'b01, 16'h0077);
      hacc(0, 8'h24, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'hA577);
      rx_push(16'h0102);
      rx_push(16'h0304);
      hacc(0, 8'h30, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'h0102);
      hacc(0, 8'h30, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'h0304);
      $display("host big-endian test done");
    end
  endtask
  task t_disk_regs;
    begin
      drv_val = 16'hC35A;
      disk_write_value_byte0 = 8'h11;
      disk_write_value_byte1 = 8'h22;
      auto_status_fetch_enable = 1;
      for (s = 0; s < 2; s = s + 1)
      begin
        // Idle edge so the last write's drive is off the bus before a read
        step;
        disk_swap = s[0];
        disk_task_file = 0;
        disk_single_read_cmd = 1;
        step;
        chk16({disk_read_value_byte0, disk_read_value_byte1}, s ? 16'h5AC3 : 16'hC35A);
        chk1(disk_rd_strobe, 1'b1);
        auto_status_fetch = 1;
        step;
        chk1(disk_rd_strobe, 1'b0);
        disk_single_write_cmd = 1;
        step;
        chk16(disk_data_bus_out, s ? 16'h2211 : 16'h1122);
        disk_burst_write_cmd = 1;
        disk_burst_write_value = 8'h33;
        step;
        disk_burst_write_value = 8'h44;
        step;
        disk_burst_write_cmd = 0;
        chk16(disk_data_bus_out, s ? 16'h3344 : 16'h4433);
        // Own drive stands one cycle; let it go before reading
        step;
        disk_task_file = 1;
        disk_single_read_cmd = 1;
        step;
        chk16({disk_read_value_byte0, disk_read_value_byte1}, 16'h5A5A);
        drv_val = 16'hC37E;
        auto_status_fetch = 1;
        step;
        chk16({disk_read_value_byte0, disk_read_value_byte1}, 16'h7E7E);
        drv_val = 16'hC35A;
        disk_single_write_cmd = 1;
        step;
        chk16(disk_data_bus_out & 16'h00FF, s ? 16'h0011 : 16'h0022);
        disk_burst_write_cmd = 1;
        disk_burst_write_value = 8'h55;
        step;
        disk_burst_write_cmd = 0;
        chk16(disk_data_bus_out & 16'h00FF, 16'h0055);
      end
      $display("disk register test done");
    end
  endtask
  task t_dma;
    begin
      for (s = 0; s < 2; s = s + 1)
      begin
        disk_swap = s[0];
        int_wr_data = 16'h1234;
        int_wr_valid = 1;
        step;
        step;
        disk_dma_launch = 1;
        disk_dma_to_disk = 1;
        disk_dma_take = 1;
        step;
        chk16(disk_data_bus_out, s ? 16'h3412 : 16'h1234);
        chk1(disk_data_bus_oe_n, 1'b0);
        chk1(disk_wr_strobe, 1'b1);
        // Release the bus before the disk answers a read
        step;
        disk_dma_to_disk = 0;
        drv_val = 16'hABCD;
        disk_dma_read_strobe = 1;
        step;
        chk16(int_rd_data, s ? 16'hCDAB : 16'hABCD);
        chk1(int_rd_valid, 1'b1);
        disk_dma_launch = 0;
      end
      $display("dma test done");
    end
  endtask
  task t_endian;
    begin
      hacc(1, 8'hB6, 2'b01, 16'h0001);
      hacc(0, 8'hB6, 2'b01, 16'h0000);
      chk16(host_data_bus_out & 16'h00FF, 16'h0001);
      hacc(0, 8'hB8, 2'b01, 16'h0000);
      hacc(0, 8'hB6, 2'b10, 16'h0000);
      chk16(host_data_bus_out & 16'hFF00, 16'h8100);
      hacc(0, 8'h24, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'hA577);
      hacc(0, 8'h24, 2'b01, 16'h0000);
      chk16(host_data_bus_out & 16'h00FF, 16'h0077);
      rx_push(16'h0506);
      hacc(0, 8'h30, 2'b11, 16'h0000);
      chk16(host_data_bus_out, 16'h0605);
      $display("host little-endian test done");
    end
  endtask
  // Main sequence
  initial
  begin
    {clk, ce, rst, drv_en} = 4'hF;
    {host_wr, host_rd, rx_valid, int_wr_valid, disk_swap, disk_task_file} = 0;
    {disk_dma_launch, disk_dma_to_disk, disk_dma_take, disk_dma_read_strobe} = 0;
    {disk_single_read_cmd, disk_single_write_cmd, auto_status_fetch_enable} = 0;
    {auto_status_fetch, disk_burst_write_cmd} = 0;
    {host_addr, disk_burst_write_value, disk_write_value_byte0, disk_write_value_byte1} = 0;
    {host_be, host_data_bus_in, rx_word, int_wr_data, drv_val} = 0;
    {mismatches, checks_done, cycles} = 0;
    repeat (13) @(negedge clk);
    rst = 0;
    step;
    t_host_be;
    t_disk_regs;
    t_dma;
    t_endian;
    print_verdict;
  end
endmodule
